// [kms_encoder.sv]
// Key matrix scan encoder: ring-counter scan, code table, debounce, strobe.
// Assumes sense inputs already synchronous to ref_clk_in and a master that
// follows Avalon-MM waitrequest signalling.
//
// The placing of the registers and the Avalon-MM interface to the registers were left to the implementer.
module kms_encoder
    import kms_pkg::*;
(
    input wire logic ref_clk_in,
    input wire logic sys_rst_in,
    input wire logic [3:0] avs_address_in,
    input wire logic avs_read_in,
    input wire logic avs_write_in,
    input wire logic [31:0] avs_writedata_in,
    input wire logic [3:0] avs_byteenable_in,
    output logic [31:0] avs_readdata_out,
    output logic avs_waitrequest_out,
    input wire logic [KMS_SENSE_N-1:0] matrix_sense_lines_in,
    output logic [KMS_DRIVE_N-1:0] matrix_drive_lines_out,
    output logic [KMS_CODE_W-1:0] code_outputs_out,
    output logic strobe_out
);

    // ************************************************************
    // Code table
    // ************************************************************
    logic [KMS_CODE_W-1:0] code_rom [KMS_WORDS];

    // Fixed contents; a different pattern is a change to this loop only
    always_comb begin
        logic [7:0] k;
        logic [7:0] c;
        k = '0;
        c = '0;
        for (int g = 0; g < KMS_GROUPS; g++) begin
            for (int i = 0; i < KMS_KEYS; i++) begin
                k = 8'(i);
                if (g == 0) begin
                    c = 8'h20 + k;
                end else if (g == 1) begin
                    c = 8'h40 + k;
                end else begin
                    c = {3'b000, k[4:0]};
                end
                code_rom[g * KMS_KEYS + i] = {~^c[6:0], c};
            end
        end
    end

    function automatic logic [3:0] onehot_idx(input logic [10:0] v);
        logic [3:0] r;
        r = '0;
        for (int i = 0; i < 11; i++) begin
            if (v[i]) begin
                r = 4'(i);
            end
        end
        return r;
    endfunction

    // ************************************************************
    // Register file
    // ************************************************************
    kms_ctrl_s ctrl, next_ctrl;
    logic [15:0] delay_cfg, next_delay_cfg;
    logic [15:0] scan_cfg, next_scan_cfg;
    logic bus_wait, next_bus_wait;
    logic [31:0] rdata, next_rdata;

    kms_state_e state, next_state;
    logic [KMS_DRIVE_N-1:0] drive_ring, next_drive_ring;
    logic [KMS_SENSE_N-1:0] sense_ring, next_sense_ring;
    logic [15:0] tick_cnt, next_tick_cnt;
    logic [15:0] deb_cnt, next_deb_cnt;
    logic [KMS_CODE_W-1:0] code_latch, next_code_latch;
    logic strobe_int, next_strobe_int;
    logic [KMS_CODE_W-1:0] next_code_out;
    logic next_strobe_out;

    function automatic logic [31:0] merge_be(input logic [31:0] old, input logic [31:0] wd,
                                             input logic [3:0] be);
        logic [31:0] r;
        r = old;
        for (int b = 0; b < 4; b++) begin
            if (be[b]) begin
                r[b*8 +: 8] = wd[b*8 +: 8];
            end
        end
        return r;
    endfunction

    // Each access is answered on the second edge: waitrequest drops for one cycle
    always_comb begin
        logic [31:0] m;
        m = '0;
        next_ctrl = ctrl;
        next_delay_cfg = delay_cfg;
        next_scan_cfg = scan_cfg;
        next_rdata = rdata;
        next_bus_wait = !((avs_read_in || avs_write_in) && bus_wait);
        if (avs_write_in && !bus_wait) begin
            if (avs_address_in == KMS_ADDR_CTRL) begin
                m = merge_be({28'h000_0000, ctrl}, avs_writedata_in, avs_byteenable_in);
                next_ctrl = kms_ctrl_s'(m[3:0]);
            end else if (avs_address_in == KMS_ADDR_DELAY) begin
                m = merge_be({16'h0000, delay_cfg}, avs_writedata_in, avs_byteenable_in);
                next_delay_cfg = m[15:0];
            end else if (avs_address_in == KMS_ADDR_SCAN) begin
                m = merge_be({16'h0000, scan_cfg}, avs_writedata_in, avs_byteenable_in);
                next_scan_cfg = m[15:0];
            end
        end
        if (avs_read_in && bus_wait) begin
            if (avs_address_in == KMS_ADDR_CTRL) begin
                next_rdata = {28'h000_0000, ctrl};
            end else if (avs_address_in == KMS_ADDR_DELAY) begin
                next_rdata = {16'h0000, delay_cfg};
            end else if (avs_address_in == KMS_ADDR_SCAN) begin
                next_rdata = {16'h0000, scan_cfg};
            end else if (avs_address_in == KMS_ADDR_STATUS) begin
                next_rdata = '0;
                next_rdata[KMS_CODE_W-1:0] = code_latch;
                next_rdata[KMS_STAT_STROBE] = strobe_int;
                next_rdata[KMS_STAT_KEY] = (state != KMS_SCAN);
            end else begin
                next_rdata = '0;
            end
        end
    end

    always_ff @(posedge ref_clk_in) begin
        if (sys_rst_in) begin
            ctrl <= KMS_CTRL_RST;
            delay_cfg <= KMS_DELAY_RST;
            scan_cfg <= KMS_SCAN_RST;
            bus_wait <= 1'b1;
            rdata <= '0;
        end else begin
            ctrl <= next_ctrl;
            delay_cfg <= next_delay_cfg;
            scan_cfg <= next_scan_cfg;
            bus_wait <= next_bus_wait;
            rdata <= next_rdata;
        end
    end

    // ************************************************************
    // Scan, detect, debounce and hold
    // ************************************************************
    logic match;
    logic scan_tick;
    logic [1:0] group;
    logic [8:0] rom_addr;

    assign match = |(matrix_sense_lines_in & sense_ring);
    assign scan_tick = (tick_cnt >= scan_cfg);
    // Control wins over shift, giving three groups from two bits
    assign group = ctrl.control_mode ? 2'h2 : (ctrl.shift_mode ? 2'h1 : 2'h0);
    assign rom_addr = 9'(group * KMS_KEYS + onehot_idx({3'b000, drive_ring}) * KMS_SENSE_N
                      + onehot_idx(sense_ring));

    always_comb begin
        next_state = state;
        next_drive_ring = drive_ring;
        next_sense_ring = sense_ring;
        next_tick_cnt = tick_cnt;
        next_deb_cnt = deb_cnt;
        next_code_latch = code_latch;
        next_strobe_int = strobe_int;
        case (state)
            KMS_SCAN: begin
                next_strobe_int = 1'b0;
                next_deb_cnt = '0;
                if (match) begin
                    // Rings freeze here, so a second key cannot take over
                    next_state = KMS_DEBOUNCE;
                    next_code_latch = code_rom[rom_addr];
                    next_tick_cnt = '0;
                end else if (scan_tick) begin
                    next_tick_cnt = '0;
                    next_sense_ring = {sense_ring[KMS_SENSE_N-2:0], sense_ring[KMS_SENSE_N-1]};
                    if (sense_ring[KMS_SENSE_N-1]) begin
                        next_drive_ring = {drive_ring[KMS_DRIVE_N-2:0], drive_ring[KMS_DRIVE_N-1]};
                    end
                end else begin
                    next_tick_cnt = tick_cnt + 16'h0001;
                end
            end
            KMS_DEBOUNCE: begin
                if (!match) begin
                    // Bounce: the contact opened before the delay ran out
                    next_state = KMS_SCAN;
                end else if (deb_cnt >= delay_cfg) begin
                    next_state = KMS_HOLD;
                    next_strobe_int = 1'b1;
                end else begin
                    next_deb_cnt = deb_cnt + 16'h0001;
                end
            end
            KMS_HOLD: begin
                if (!match) begin
                    next_state = KMS_SCAN;
                    next_strobe_int = 1'b0;
                end
            end
            default: begin
                next_state = KMS_SCAN;
            end
        endcase
    end

    // Polarity is applied on the output stage so a change shows one edge after the write lands
    always_comb begin
        next_code_out = code_latch;
        next_code_out[KMS_PAR_BIT] = code_latch[KMS_PAR_BIT] ^ ctrl.par_inv;
        next_code_out[7:0] = code_latch[7:0] ^ {8{ctrl.ds_inv}};
        next_strobe_out = strobe_int ^ ctrl.ds_inv;
    end

    always_ff @(posedge ref_clk_in) begin
        if (sys_rst_in) begin
            state <= KMS_SCAN;
            drive_ring <= KMS_DRIVE_RST;
            sense_ring <= KMS_SENSE_RST;
            tick_cnt <= '0;
            deb_cnt <= '0;
            code_latch <= '0;
            strobe_int <= 1'b0;
            code_outputs_out <= '0;
            strobe_out <= 1'b0;
        end else begin
            state <= next_state;
            drive_ring <= next_drive_ring;
            sense_ring <= next_sense_ring;
            tick_cnt <= next_tick_cnt;
            deb_cnt <= next_deb_cnt;
            code_latch <= next_code_latch;
            strobe_int <= next_strobe_int;
            code_outputs_out <= next_code_out;
            strobe_out <= next_strobe_out;
        end
    end

    assign matrix_drive_lines_out = drive_ring;
    assign avs_readdata_out = rdata;
    assign avs_waitrequest_out = bus_wait;

    // ************************************************************
    // Checks
    // ************************************************************
    a_bus_answer: assert property (@(posedge ref_clk_in) disable iff (sys_rst_in)
        (avs_read_in || avs_write_in) && bus_wait |=> !bus_wait ##1 bus_wait)
        else $error("bus request not answered in one cycle");
    a_scan_steps: assert property (@(posedge ref_clk_in) disable iff (sys_rst_in)
        state == KMS_SCAN && !match && scan_tick |=>
        sense_ring == {$past(sense_ring[KMS_SENSE_N-2:0]), $past(sense_ring[KMS_SENSE_N-1])})
        else $error("sense ring did not step");
    a_rings_halt: assert property (@(posedge ref_clk_in) disable iff (sys_rst_in)
        state != KMS_SCAN |=> $stable(drive_ring) && $stable(sense_ring))
        else $error("rings moved while a key is held");
    a_code_stable: assert property (@(posedge ref_clk_in) disable iff (sys_rst_in)
        state != KMS_SCAN |=> $stable(code_latch))
        else $error("code changed while key held");
    a_strobe_idle: assert property (@(posedge ref_clk_in) disable iff (sys_rst_in)
        state == KMS_SCAN && $past(state) == KMS_SCAN |-> !strobe_int)
        else $error("strobe active during scan");
    a_strobe_after_delay: assert property (@(posedge ref_clk_in) disable iff (sys_rst_in)
        $rose(strobe_int) |-> $past(state) == KMS_DEBOUNCE && $past(deb_cnt) >= $past(delay_cfg))
        else $error("strobe rose without full debounce");
    a_release_drop: assert property (@(posedge ref_clk_in) disable iff (sys_rst_in)
        state == KMS_HOLD && !match |=> state == KMS_SCAN && !strobe_int)
        else $error("release not followed by rescan");
    a_parity_odd: assert property (@(posedge ref_clk_in) disable iff (sys_rst_in)
        strobe_int |-> ^{code_latch[KMS_PAR_BIT], code_latch[6:0]})
        else $error("parity is not odd");
    a_parity_pol: assert property (@(posedge ref_clk_in) disable iff (sys_rst_in)
        !$past(sys_rst_in) |-> code_outputs_out[KMS_PAR_BIT] ==
        ($past(code_latch[KMS_PAR_BIT]) ^ $past(ctrl.par_inv)))
        else $error("parity polarity wrong");
    a_data_pol: assert property (@(posedge ref_clk_in) disable iff (sys_rst_in)
        !$past(sys_rst_in) |-> code_outputs_out[7:0] == ($past(code_latch[7:0]) ^ {8{$past(ctrl.ds_inv)}})
        && strobe_out == ($past(strobe_int) ^ $past(ctrl.ds_inv)))
        else $error("data or strobe polarity wrong");

    c_detect: cover property (@(posedge ref_clk_in) disable iff (sys_rst_in)
        state == KMS_SCAN ##1 state == KMS_DEBOUNCE);
    c_valid: cover property (@(posedge ref_clk_in) disable iff (sys_rst_in) $rose(strobe_int));
    c_bounce: cover property (@(posedge ref_clk_in) disable iff (sys_rst_in)
        state == KMS_DEBOUNCE ##1 state == KMS_SCAN);
    c_release: cover property (@(posedge ref_clk_in) disable iff (sys_rst_in)
        state == KMS_HOLD ##1 state == KMS_SCAN);

endmodule

// [kms_pkg.sv]
// Shared constants and types for the key matrix scan encoder.
// Assumes a single 250 MHz clock and an Avalon-MM register slave.
package kms_pkg;

    // ************************************************************
    // Matrix and code table geometry
    // ************************************************************
    localparam int KMS_DRIVE_N = 8;
    localparam int KMS_SENSE_N = 11;
    localparam int KMS_KEYS = 88;
    localparam int KMS_GROUPS = 3;
    localparam int KMS_WORDS = 264;
    localparam int KMS_CODE_W = 9;
    localparam int KMS_PAR_BIT = 8;

    // ************************************************************
    // Register map (byte addresses) and reset values
    // ************************************************************
    localparam logic [3:0] KMS_ADDR_CTRL = 4'h0;
    localparam logic [3:0] KMS_ADDR_DELAY = 4'h4;
    localparam logic [3:0] KMS_ADDR_SCAN = 4'h8;
    localparam logic [3:0] KMS_ADDR_STATUS = 4'hC;
    localparam logic [15:0] KMS_DELAY_RST = 16'h0FA0;
    localparam logic [15:0] KMS_SCAN_RST = 16'h0019;
    localparam logic [7:0] KMS_DRIVE_RST = 8'h01;
    localparam logic [10:0] KMS_SENSE_RST = 11'h001;

    // Control register field positions
    localparam int KMS_CTRL_SHIFT = 0;
    localparam int KMS_CTRL_CONTROL = 1;
    localparam int KMS_CTRL_PAR_INV = 2;
    localparam int KMS_CTRL_DS_INV = 3;
    // Status register field positions
    localparam int KMS_STAT_STROBE = 9;
    localparam int KMS_STAT_KEY = 10;

    typedef struct packed {
        logic ds_inv;
        logic par_inv;
        logic control_mode;
        logic shift_mode;
    } kms_ctrl_s;

    localparam kms_ctrl_s KMS_CTRL_RST = '0;

    typedef enum logic [1:0] {
        KMS_SCAN,
        KMS_DEBOUNCE,
        KMS_HOLD
    } kms_state_e;

endpackage

// [kms_keyboard_model.sv]
// Keyboard switch matrix model for the key matrix scan encoder.
// Assumes one-hot drive lines and sense lines sampled on ref_clk_in.
module kms_keyboard_model
    import kms_pkg::*;
(
    input wire logic [KMS_DRIVE_N-1:0] drive_lines_in,
    input wire logic [1:0] key_en_in,
    input wire logic [1:0][2:0] key_row_in,
    input wire logic [1:0][3:0] key_col_in,
    output logic [KMS_SENSE_N-1:0] sense_lines_out
);
    // ************************************************************
    // Switch crosspoints
    // ************************************************************
    // Open sense lines rest at the pull-down level, never at a stale value
    always_comb begin
        sense_lines_out = '0;
        for (int i = 0; i < 2; i++) begin
            if (key_en_in[i] && drive_lines_in[key_row_in[i]]) begin
                sense_lines_out[key_col_in[i]] = 1'b1;
            end
        end
    end
endmodule

// [kms_encoder_bench.sv]
// Self-checking bench for the key matrix scan encoder.
// Assumes the keyboard model on the matrix side and an Avalon-MM master here.
module kms_encoder_bench
    import kms_pkg::*;
;
    timeunit 1ns;
    timeprecision 100ps;
    logic ref_clk_in = 1'b0;
    logic sys_rst_in = 1'b1;
    logic [3:0] avs_address_in = 4'h0;
    logic avs_read_in = 1'b0;
    logic avs_write_in = 1'b0;
    logic [31:0] avs_writedata_in = 32'h0000_0000;
    logic [3:0] avs_byteenable_in = 4'hF;
    logic [31:0] avs_readdata_out;
    logic avs_waitrequest_out;
    logic [KMS_SENSE_N-1:0] sense;
    logic [KMS_DRIVE_N-1:0] drive;
    logic [8:0] code;
    logic strobe_out;
    logic [1:0] key_en = 2'h0;
    logic [1:0][2:0] key_row = '0;
    logic [1:0][3:0] key_col = '0;
    logic [31:0] rd;
    int mismatches = 0;
    int samples_checked = 0;
    int rows [7] = '{0, 7, 3, 5, 1, 6, 2};
    int cols [7] = '{0, 10, 9, 4, 1, 8, 5};
    logic [3:0] ctls [7] = '{4'h0, 4'h1, 4'h2, 4'h3, 4'h4, 4'h8, 4'hE};

    always #2 ref_clk_in = ~ref_clk_in;

    kms_encoder dut_u (.ref_clk_in(ref_clk_in), .sys_rst_in(sys_rst_in), .avs_address_in(avs_address_in),
        .avs_read_in(avs_read_in), .avs_write_in(avs_write_in), .avs_writedata_in(avs_writedata_in),
        .avs_byteenable_in(avs_byteenable_in), .avs_readdata_out(avs_readdata_out),
        .avs_waitrequest_out(avs_waitrequest_out), .matrix_sense_lines_in(sense),
        .matrix_drive_lines_out(drive), .code_outputs_out(code), .strobe_out(strobe_out));
    kms_keyboard_model kbd_u (.drive_lines_in(drive), .key_en_in(key_en), .key_row_in(key_row),
        .key_col_in(key_col), .sense_lines_out(sense));

    // ************************************************************
    // Shared tasks
    // ************************************************************
    task automatic check(input logic [31:0] got, input logic [31:0] exp);
        samples_checked++;
        if (got !== exp) begin
            mismatches++;
            $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    task automatic conclude();
        $display("checks=%0d mismatches=%0d", samples_checked, mismatches);
        if (mismatches == 0 && samples_checked > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask

    // Holds the request until waitrequest is sampled low, then releases it
    task automatic bus(input logic wr, input logic [3:0] a, input logic [31:0] wd);
        int n;
        n = 0;
        avs_address_in <= a;
        avs_writedata_in <= wd;
        avs_read_in <= ~wr;
        avs_write_in <= wr;
        // No local limit: only the watchdog ends a wait that never completes
        do begin
            @(posedge ref_clk_in);
            n++;
        end while (avs_waitrequest_out !== 1'b0);
        // Request taken at the first edge, answered at the second
        check(32'(n), 32'h0000_0002);
        rd = avs_readdata_out;
        avs_read_in <= 1'b0;
        avs_write_in <= 1'b0;
        @(posedge ref_clk_in);
    endtask

    function automatic logic [8:0] exp_code(input int r, input int c, input logic [3:0] ctl);
        logic [7:0] v;
        v = ctl[1] ? 8'(r * 11 + c) & 8'h1F : ctl[0] ? 8'(8'h40 + r * 11 + c) : 8'(8'h20 + r * 11 + c);
        return {~^v[6:0] ^ ctl[2], v ^ {8{ctl[3]}}};
    endfunction

    task automatic wait_strobe(input logic lvl, input int lim, output int n);
        n = 0;
        while (strobe_out !== lvl && n < lim) begin
            @(posedge ref_clk_in);
            n++;
        end
    endtask

    // ************************************************************
    // Scenarios
    // ************************************************************
    task automatic t_reset();
        check({13'h0, drive, code, strobe_out, avs_waitrequest_out}, 32'h0000_0801);
        bus(1'b0, KMS_ADDR_CTRL, 32'h0000_0000);
        check(rd, 32'h0000_0000);
        bus(1'b0, KMS_ADDR_DELAY, 32'h0000_0000);
        check(rd, 32'h0000_0FA0);
        bus(1'b0, KMS_ADDR_SCAN, 32'h0000_0000);
        check(rd, 32'h0000_0019);
        // Only the low byte lane may land
        avs_byteenable_in <= 4'h1;
        bus(1'b1, KMS_ADDR_DELAY, 32'h1234_5678);
        avs_byteenable_in <= 4'hF;
        bus(1'b0, KMS_ADDR_DELAY, 32'h0000_0000);
        check(rd, 32'h0000_0F78);
        bus(1'b1, 4'h1, 32'h0000_000F);
        bus(1'b0, 4'h1, 32'h0000_0000);
        check(rd, 32'h0000_0000);
        bus(1'b0, KMS_ADDR_CTRL, 32'h0000_0000);
        check(rd, 32'h0000_0000);
        bus(1'b1, KMS_ADDR_DELAY, 32'h0000_0002);
        bus(1'b1, KMS_ADDR_SCAN, 32'h0000_0000);
    endtask

    task automatic t_idle();
        logic [7:0] p;
        logic [7:0] seen;
        int n;
        int hi;
        p = drive;
        for (int i = 0; i < 40 && drive === p; i++) @(posedge ref_clk_in);
        p = drive;
        n = 0;
        while (drive === p && n < 40) begin
            @(posedge ref_clk_in);
            n++;
        end
        check(32'(n), 32'h0000_000B);
        seen = '0;
        hi = 0;
        repeat (100) begin
            @(posedge ref_clk_in);
            seen |= drive;
            hi += (strobe_out !== 1'b0);
        end
        check({24'h0, seen}, 32'h0000_00FF);
        check(32'(hi), 32'h0000_0000);
    endtask

    task automatic t_encode(input int r, input int c, input logic [3:0] ctl);
        int n;
        int bad;
        bus(1'b1, KMS_ADDR_CTRL, {28'h0, ctl});
        // The strobe pin takes the new polarity one edge after the write lands
        @(posedge ref_clk_in);
        key_row[0] <= 3'(r);
        key_col[0] <= 4'(c);
        key_en[0] <= 1'b1;
        wait_strobe(~ctl[3], 200, n);
        check({23'h0, code}, {23'h0, exp_code(r, c, ctl)});
        check({24'h0, drive}, 32'(1 << r));
        bad = 0;
        // Key stays closed for 20 more edges after the strobe; code and drive must not move
        repeat (20) begin
            @(posedge ref_clk_in);
            bad += (code !== exp_code(r, c, ctl)) || (drive !== 8'(1 << r));
        end
        check(32'(bad), 32'h0000_0000);
        bus(1'b0, KMS_ADDR_STATUS, 32'h0000_0000);
        check(rd, {21'h0, 2'b11, exp_code(r, c, {2'b00, ctl[1:0]})});
        key_en[0] <= 1'b0;
        wait_strobe(ctl[3], 4, n);
        check({31'h0, strobe_out}, {31'h0, ctl[3]});
        for (int i = 0; i < 20 && drive === 8'(1 << r); i++) @(posedge ref_clk_in);
        check({31'h0, drive !== 8'(1 << r)}, 32'h0000_0001);
    endtask

    task automatic t_bounce();
        int n;
        bus(1'b1, KMS_ADDR_CTRL, 32'h0000_0000);
        bus(1'b1, KMS_ADDR_DELAY, 32'h0000_001E);
        key_row[0] <= 3'h4;
        key_col[0] <= 4'h2;
        // Close the contact one row early so it is found right after row four comes up
        for (int i = 0; i < 100 && drive !== 8'h08; i++) @(posedge ref_clk_in);
        key_en[0] <= 1'b1;
        for (int i = 0; i < 100 && drive !== 8'h10; i++) @(posedge ref_clk_in);
        repeat (12) @(posedge ref_clk_in);
        key_en[0] <= 1'b0;
        wait_strobe(1'b1, 60, n);
        check({31'h0, strobe_out}, 32'h0000_0000);
        key_en[0] <= 1'b1;
        wait_strobe(1'b1, 200, n);
        check({31'h0, n >= 30}, 32'h0000_0001);
        key_en[0] <= 1'b0;
        wait_strobe(1'b0, 4, n);
        bus(1'b1, KMS_ADDR_DELAY, 32'h0000_0002);
    endtask

    task automatic t_rollover();
        int n;
        key_row <= {3'h6, 3'h1};
        key_col <= {4'h7, 4'h3};
        key_en <= 2'b01;
        wait_strobe(1'b1, 200, n);
        key_en <= 2'b11;
        repeat (40) @(posedge ref_clk_in);
        check({23'h0, code}, {23'h0, exp_code(1, 3, 4'h0)});
        key_en <= 2'b10;
        wait_strobe(1'b0, 4, n);
        check({31'h0, strobe_out}, 32'h0000_0000);
        wait_strobe(1'b1, 200, n);
        check({23'h0, code}, {23'h0, exp_code(6, 7, 4'h0)});
        key_en <= 2'b00;
        wait_strobe(1'b0, 4, n);
    endtask

    // ************************************************************
    // Main sequence and watchdog
    // ************************************************************
    initial begin
        repeat (10) @(posedge ref_clk_in);
        sys_rst_in <= 1'b0;
        @(posedge ref_clk_in);
        t_reset();
        t_idle();
        for (int i = 0; i < 7; i++) begin
            t_encode(rows[i], cols[i], ctls[i]);
        end
        t_bounce();
        t_rollover();
        conclude();
    end

    initial begin
        repeat (20000) @(posedge ref_clk_in);
        mismatches++;
        conclude();
    end
endmodule
